/* hw/tbcp_pkg.sv */
// constants, field layouts and carrier types for the buffered cascade pwm timer
package tbcp_pkg;

  // ----------------------------------------------------------------
  // structure
  // ----------------------------------------------------------------
  localparam int CH_N = 5;
  localparam int GR_N = 4;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [2:0] CH_LAST = 3'h4;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_IO = 5'h04;
  localparam logic [4:0] OFF_BTM = 5'h08;
  localparam logic [4:0] OFF_CNT = 5'h0c;
  localparam logic [7:0] ADR_GRE = 8'ha0;
  localparam logic [7:0] ADR_GRF = 8'ha4;
  localparam logic [7:0] ADR_XCAP = 8'ha8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BTM_BUF_A = 0;
  localparam int BTM_BUF_E = 2;
  localparam int BTM_TTS_A = 3;
  localparam int BTM_TTS_E = 5;
  localparam int IO_CAP = 3;
  localparam int IO_INIT = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_GR = 16'hffff;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [15:0] RST_IO = 16'h0000;
  localparam logic [5:0] RST_BTM = 6'h00;
  localparam logic [3:0] RST_XCAP = 4'h0;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] CLR_A = 3'h1;
  localparam logic [2:0] CLR_B = 3'h2;
  localparam logic [2:0] CLR_SYNC = 3'h3;
  localparam logic [2:0] CLR_C = 3'h5;
  localparam logic [2:0] CLR_D = 3'h6;
  localparam logic [1:0] OUT_LO = 2'h1;
  localparam logic [1:0] OUT_HI = 2'h2;
  localparam logic [1:0] OUT_TGL = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;

  typedef enum logic [1:0] {
    TBCP_NORMAL,
    TBCP_PWM1,
    TBCP_PWM2
  } tbcp_pwm_e;

  // counter_control word, bit 7 down to bit 0
  typedef struct packed {
    logic casc;
    logic phase;
    tbcp_pwm_e pwm;
    logic [2:0] clear_source_sel;
    logic run;
  } tbcp_ctl_s;

endpackage

/* hw/tbcp_top.sv */
// buffered general registers, 32-bit cascade and pwm modes 1/2 of a 5-channel timer
//
// What this block does
// - buffer pairs exist on channels 0, 3, 4; c/d buffer a/b, f buffers e
// - compare match on buffered register loads it from its buffer
// - capture loads count, old general value moves into the buffer
// - transfer moment selectable: ch0 pwm1/2, ch3/4 pwm1; else compare match
// - clear transfer on overflow, zero written while counting, or counter clear
// - timing select 0 means compare match, 1 means counter clearing
// - cascade: channel 1 is upper half, channel 2 lower half
// - cascaded channel 1 counts up on ch2 overflow, down on underflow
// - lower counter underflow only exists in phase counting mode
// - channel 1 in phase counting ignores the cascade clock choice
// - enabled extra pin is ored with main pin before edge detection
// - four cross capture bits add the other channel's same-letter pin
// - capture from another channel's event ignores the extra pin
// - pwm compare match drives pin 0, 1 or toggle; duty 0 to 100%
// - pwm per channel; clear-source match register sets the period
// - pwm mode 1 pairs a/b and c/d onto pins a and c
// - pwm mode 1 initial level comes from the a or c setting
// - pwm mode 1 equal pair values leave the pin unchanged
// - pwm mode 1 gives up to ten output phases
// - pwm mode 2 cycle match clear returns pins to initial level
// - pwm mode 2 duty equal to cycle leaves the pin unchanged
// - pwm mode 2 with synchronous clearing gives up to twenty phases
// - pwm mode 2 period register drives no pin
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module tbcp_top #(
  parameter int CW = tbcp_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [4:0] count_tick,
  input wire logic [4:0] phase_up,
  input wire logic [4:0] phase_dn,
  input wire logic [4:0] sync_clear,
  input wire logic [4:0][3:0] cap_alt,
  input wire logic [4:0][3:0] pin_in,
  output logic [4:0][3:0] pin_out,
  output logic [4:0][3:0] pin_oe_n
);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic [31:0] a_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic take;
  logic mapped;
  logic [31:0] rd_next;
  logic [7:0] ctl_w [5];
  logic [15:0] io_w [5];
  logic [5:0] btm_w [5];
  logic [CW-1:0] cnt_w [5];
  logic [CW-1:0] gr_w [5][4];
  logic [4:0] tick_w;
  logic [4:0] clrx_w;
  logic [4:0] tmg_w;
  logic [4:0] ovf_w;
  logic [4:0] unf_w;
  logic [CW-1:0] gre_reg;
  logic [CW-1:0] grf_reg;
  logic [3:0] xcap_reg;

  assign take = hsel && htrans[1] && hready;
  assign mapped = (a_reg[31:8] == 24'h000000);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_reg <= 32'h00000000;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
    end else if (ce) begin
      if (take) begin
        a_reg <= haddr;
      end
      wr_pend_reg <= take && hwrite;
      rd_pend_reg <= take && !hwrite;
    end
  end

  // reads take one wait state so that hrdata comes from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else if (ce) begin
      hresp <= 1'b0;
      if (rd_pend_reg && !hreadyout) begin
        hrdata <= rd_next;
        hreadyout <= 1'b1;
      end else if (take && !hwrite) begin
        hreadyout <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_next = 32'h00000000;
    if (mapped && a_reg[7:5] <= tbcp_pkg::CH_LAST) begin
      case (a_reg[4:0])
        tbcp_pkg::OFF_CTRL: rd_next[7:0] = ctl_w[a_reg[7:5]];
        tbcp_pkg::OFF_IO: rd_next[15:0] = io_w[a_reg[7:5]];
        tbcp_pkg::OFF_BTM: rd_next[5:0] = btm_w[a_reg[7:5]];
        tbcp_pkg::OFF_CNT: rd_next[CW-1:0] = cnt_w[a_reg[7:5]];
        default: begin
          if (a_reg[4]) begin
            rd_next[CW-1:0] = gr_w[a_reg[7:5]][a_reg[3:2]];
          end
        end
      endcase
    end else if (mapped) begin
      case (a_reg[7:0])
        tbcp_pkg::ADR_GRE: rd_next[CW-1:0] = gre_reg;
        tbcp_pkg::ADR_GRF: rd_next[CW-1:0] = grf_reg;
        tbcp_pkg::ADR_XCAP: rd_next[3:0] = xcap_reg;
        default: rd_next = 32'h00000000;
      endcase
    end
  end

  function automatic logic lvl(input logic p, input logic [1:0] m);
    case (m)
      tbcp_pkg::OUT_LO: lvl = 1'b0;
      tbcp_pkg::OUT_HI: lvl = 1'b1;
      tbcp_pkg::OUT_TGL: lvl = !p;
      default: lvl = p;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  for (genvar i = 0; i < tbcp_pkg::CH_N; i++) begin : g_ch
    localparam bit BUF_OK = (i == 0) || (i == 3) || (i == 4);
    tbcp_pkg::tbcp_ctl_s c;
    logic [7:0] ctl_reg;
    logic [15:0] io_reg;
    logic [5:0] btm_reg;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] gr_reg [4];
    logic [3:0] prv_reg;
    logic [3:0] pin_reg;
    logic [3:0] oe_n_reg;
    logic wsel;
    logic casc;
    logic up;
    logic dn;
    logic tick;
    logic clr_evt;
    logic zw;
    logic clr_x;
    logic tmg_ok;
    logic cv;
    logic [1:0] cyc;
    logic [3:0] xp;
    logic [3:0] sig;
    logic [3:0] ic;
    logic [3:0] cap;
    logic [3:0] match;
    logic [3:0] ev;
    logic [1:0] bon;
    logic [1:0] xf;

    assign c = tbcp_pkg::tbcp_ctl_s'(ctl_reg);
    assign wsel = wr_pend_reg && mapped && (a_reg[7:5] == 3'(i));
    assign casc = (i == 1) && c.casc && !c.phase;
    assign up = c.phase ? phase_up[i] : (casc ? ovf_w[2] : count_tick[i]);
    assign dn = c.phase ? phase_dn[i] : (casc && unf_w[2]);
    assign tick = c.run && (up || dn);
    assign xp = (i == 1) ? {2'b00, xcap_reg[1:0] & pin_in[2][1:0]} :
                (i == 2) ? {2'b00, xcap_reg[3:2] & pin_in[1][1:0]} : 4'h0;

    for (genvar k = 0; k < tbcp_pkg::GR_N; k++) begin : g_gr
      logic [1:0] eg;
      assign eg = io_reg[4*k+1:4*k];
      assign ic[k] = io_reg[4*k+tbcp_pkg::IO_CAP];
      // an other-channel source replaces the pins entirely
      assign sig[k] = io_reg[4*k+2] ? cap_alt[i][k] : (pin_in[i][k] | xp[k]);
      assign cap[k] = c.run && ic[k] && (((eg == tbcp_pkg::EDGE_RISE) && sig[k] && !prv_reg[k]) ||
                      ((eg == tbcp_pkg::EDGE_FALL) && !sig[k] && prv_reg[k]) ||
                      (eg[1] && (sig[k] != prv_reg[k])));
      assign match[k] = !ic[k] && tick && (cnt_reg == gr_reg[k]);
      assign ev[k] = match[k] || cap[k];
    end

    always_comb begin
      cv = 1'b1;
      cyc = 2'h3;
      clr_evt = 1'b0;
      case (c.clear_source_sel)
        tbcp_pkg::CLR_A: begin
          cyc = 2'h0;
          clr_evt = ev[0];
        end
        tbcp_pkg::CLR_B: begin
          cyc = 2'h1;
          clr_evt = ev[1];
        end
        tbcp_pkg::CLR_C: begin
          cyc = 2'h2;
          clr_evt = ev[2];
        end
        tbcp_pkg::CLR_D: clr_evt = ev[3];
        tbcp_pkg::CLR_SYNC: begin
          cv = 1'b0;
          clr_evt = c.run && sync_clear[i];
        end
        default: cv = 1'b0;
      endcase
    end

    assign zw = c.run && wsel && (a_reg[4:0] == tbcp_pkg::OFF_CNT) && (hwdata[CW-1:0] == '0);
    assign ovf_w[i] = tick && up && !dn && (cnt_reg == '1) && !clr_evt;
    assign unf_w[i] = tick && dn && c.phase && (cnt_reg == '0) && !clr_evt;
    assign clr_x = ovf_w[i] || zw || clr_evt;
    assign tmg_ok = ((i == 0) && (c.pwm != tbcp_pkg::TBCP_NORMAL)) ||
                    (((i == 3) || (i == 4)) && (c.pwm == tbcp_pkg::TBCP_PWM1));
    for (genvar j = 0; j < 2; j++) begin : g_buf
      assign bon[j] = BUF_OK && btm_reg[tbcp_pkg::BTM_BUF_A+j];
      assign xf[j] = !ic[j] && ((btm_reg[tbcp_pkg::BTM_TTS_A+j] && tmg_ok) ? clr_x : match[j]);
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ctl_reg <= tbcp_pkg::RST_CTL;
        io_reg <= tbcp_pkg::RST_IO;
        btm_reg <= tbcp_pkg::RST_BTM;
      end else if (ce && wsel) begin
        if (a_reg[4:0] == tbcp_pkg::OFF_CTRL) begin
          ctl_reg <= hwdata[7:0];
        end
        if (a_reg[4:0] == tbcp_pkg::OFF_IO) begin
          io_reg <= hwdata[15:0];
        end
        // mode is only changed by software with the counter stopped
        if (a_reg[4:0] == tbcp_pkg::OFF_BTM) begin
          btm_reg <= hwdata[5:0];
        end
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_reg <= tbcp_pkg::RST_CNT;
        prv_reg <= 4'h0;
      end else if (ce) begin
        prv_reg <= sig;
        if (wsel && (a_reg[4:0] == tbcp_pkg::OFF_CNT)) begin
          cnt_reg <= hwdata[CW-1:0];
        end else if (clr_evt) begin
          cnt_reg <= '0;
        end else if (tick && up) begin
          cnt_reg <= cnt_reg + 1'b1;
        end else if (tick && dn) begin
          cnt_reg <= cnt_reg - 1'b1;
        end
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        for (int k = 0; k < 4; k++) begin
          gr_reg[k] <= tbcp_pkg::RST_GR;
        end
      end else if (ce) begin
        for (int k = 0; k < 4; k++) begin
          if (wsel && a_reg[4] && (a_reg[3:2] == 2'(k))) begin
            gr_reg[k] <= hwdata[CW-1:0];
          end
          if (cap[k] && !((k > 1) && bon[k%2])) begin
            gr_reg[k] <= cnt_reg;
          end
        end
        for (int j = 0; j < 2; j++) begin
          if (bon[j] && cap[j]) begin
            gr_reg[j+2] <= gr_reg[j];
          end else if (bon[j] && xf[j]) begin
            gr_reg[j] <= gr_reg[j+2];
          end
        end
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pin_reg <= 4'h0;
        oe_n_reg <= 4'hf;
      end else if (ce) begin
        for (int k = 0; k < 4; k++) begin
          case (c.pwm)
            tbcp_pkg::TBCP_PWM1: oe_n_reg[k] <= k[0] || ic[k];
            tbcp_pkg::TBCP_PWM2: oe_n_reg[k] <= ic[k] || (cv && (cyc == 2'(k)));
            default: oe_n_reg[k] <= ic[k] || (io_reg[4*k +: 2] == 2'h0);
          endcase
        end
        if (wsel && (a_reg[4:0] == tbcp_pkg::OFF_IO)) begin
          for (int k = 0; k < 4; k++) begin
            pin_reg[k] <= hwdata[4*k+tbcp_pkg::IO_INIT];
          end
        end else begin
          case (c.pwm)
            tbcp_pkg::TBCP_PWM1: begin
              for (int p = 0; p < 4; p += 2) begin
                if (gr_reg[p] != gr_reg[p+1]) begin
                  if (match[p+1]) begin
                    pin_reg[p] <= lvl(pin_reg[p], io_reg[4*p+4 +: 2]);
                  end else if (match[p]) begin
                    pin_reg[p] <= lvl(pin_reg[p], io_reg[4*p +: 2]);
                  end
                end
              end
            end
            tbcp_pkg::TBCP_PWM2: begin
              for (int k = 0; k < 4; k++) begin
                if (clr_evt) begin
                  pin_reg[k] <= io_reg[4*k+tbcp_pkg::IO_INIT];
                end else if (match[k] && !(cv && ((cyc == 2'(k)) || (gr_reg[k] == gr_reg[cyc])))) begin
                  pin_reg[k] <= lvl(pin_reg[k], io_reg[4*k +: 2]);
                end
              end
            end
            default: begin
              for (int k = 0; k < 4; k++) begin
                if (match[k]) begin
                  pin_reg[k] <= lvl(pin_reg[k], io_reg[4*k +: 2]);
                end
              end
            end
          endcase
        end
      end
    end

    assign pin_out[i] = pin_reg;
    assign pin_oe_n[i] = oe_n_reg;
    assign ctl_w[i] = ctl_reg;
    assign io_w[i] = io_reg;
    assign btm_w[i] = btm_reg;
    assign cnt_w[i] = cnt_reg;
    assign tick_w[i] = tick;
    assign clrx_w[i] = clr_x;
    assign tmg_w[i] = tmg_ok;
    for (genvar k = 0; k < 4; k++) begin : g_rd
      assign gr_w[i][k] = gr_reg[k];
    end
  end

  // ----------------------------------------------------------------
  // channel 0 e/f pair and cross capture control
  // ----------------------------------------------------------------
  logic match_e;
  logic xf_e;
  logic wr_top;

  assign wr_top = wr_pend_reg && mapped;
  assign match_e = tick_w[0] && (cnt_w[0] == gre_reg);
  assign xf_e = btm_w[0][tbcp_pkg::BTM_BUF_E] &&
                ((btm_w[0][tbcp_pkg::BTM_TTS_E] && tmg_w[0]) ? clrx_w[0] : match_e);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gre_reg <= tbcp_pkg::RST_GR;
      grf_reg <= tbcp_pkg::RST_GR;
      xcap_reg <= tbcp_pkg::RST_XCAP;
    end else if (ce) begin
      if (wr_top && (a_reg[7:0] == tbcp_pkg::ADR_GRE)) begin
        gre_reg <= hwdata[CW-1:0];
      end
      if (xf_e) begin
        gre_reg <= grf_reg;
      end
      if (wr_top && (a_reg[7:0] == tbcp_pkg::ADR_GRF)) begin
        grf_reg <= hwdata[CW-1:0];
      end
      if (wr_top && (a_reg[7:0] == tbcp_pkg::ADR_XCAP)) begin
        xcap_reg <= hwdata[3:0];
      end
    end
  end

endmodule

/* test/tbcp_assertions.sv */
// port-level checker for the buffered cascade pwm timer
`timescale 1ns/1ps
module tbcp_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [4:0] count_tick,
  input wire logic [4:0] phase_up,
  input wire logic [4:0] phase_dn,
  input wire logic [4:0] sync_clear,
  input wire logic [4:0][3:0] pin_out,
  input wire logic [4:0][3:0] pin_oe_n
);
  // ----------------------------------------
  // helper
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic step;
  logic wr_dp;
  assign take = ce && hsel && htrans[1] && hready;
  assign step = |count_tick || |phase_up || |phase_dn || |sync_clear;
  // marks the data phase of a register write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_dp <= 1'b0;
    end else if (ce) begin
      wr_dp <= take && hwrite;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read lacks its single wait state");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write was stalled");
  ready_idle_a: assert property (hreadyout && !(take && !hwrite) |=> hreadyout)
    else $error("ready dropped without a read");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("error response seen");
  rdata_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data moved outside a read");
  ce_freeze_a: assert property (!ce |=> $stable(pin_out) && $stable(pin_oe_n) && $stable(hrdata))
    else $error("outputs moved with clock enable low");
  pin_cause_a: assert property ($changed(pin_out) |-> $past(wr_dp) || $past(step))
    else $error("pin changed without a count step or write");
  oe_cause_a: assert property ($changed(pin_oe_n) |-> $past(wr_dp) || $past(wr_dp, 2))
    else $error("drive enable changed without a write");
  cover property (take && !hwrite);
  cover property ($changed(pin_out));
  cover property (!ce);
endmodule

/* test/tbcp_pins_model.sv */
// pin loads and signal sources: resolves each timer pin wire
`timescale 1ns/1ps
module tbcp_pins_model (
  input wire logic [4:0][3:0] pin_out,
  input wire logic [4:0][3:0] pin_oe_n,
  input wire logic [4:0][3:0] src,
  output logic [4:0][3:0] pin_in
);
  // a source drives only where the timer leaves the pin undriven
  assign pin_in = (pin_oe_n & src) | (~pin_oe_n & pin_out);
endmodule

/* test/tbcp_top_tb.sv */
// self-checking bench for the buffered cascade pwm timer
`timescale 1ns/1ps
module tbcp_top_tb;
  logic clk;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp;
  logic [4:0] count_tick = '0, phase_up = '0, phase_dn = '0, sync_clear = '0;
  logic [4:0][3:0] cap_alt = '0, src = '0, pin_in, pin_out, pin_oe_n;
  int miscompares = 0;
  int checks_done = 0;
  typedef struct {logic [31:0] a; logic wr; logic [31:0] d; logic [31:0] e;} tbcp_row_s;
  tbcp_row_s rows [14] = '{
    '{32'h0, 1'b0, 32'h0, 32'h0}, '{32'h4, 1'b0, 32'h0, 32'h0}, '{32'h8, 1'b0, 32'h0, 32'h0},
    '{32'hc, 1'b0, 32'h0, 32'h0}, '{32'h10, 1'b0, 32'h0, 32'hffff}, '{32'h9c, 1'b0, 32'h0, 32'hffff},
    '{32'ha0, 1'b0, 32'h0, 32'hffff}, '{32'ha4, 1'b0, 32'h0, 32'hffff}, '{32'ha8, 1'b0, 32'h0, 32'h0},
    '{32'h10, 1'b1, 32'h1234, 32'h1234}, '{32'ha4, 1'b1, 32'h55aa, 32'h55aa},
    '{32'ha8, 1'b1, 32'hf, 32'hf}, '{32'hac, 1'b1, 32'h1234, 32'h0}, '{32'h100, 1'b1, 32'hffff, 32'h0}};
  logic [31:0] pe [5] = '{32'h4, 32'h6, 32'ha, 32'h4, 32'h4};
  logic [31:0] ga [5] = '{32'h5, 32'h3, 32'h9, 32'h5, 32'h5};

  tbcp_top tbcp_top_i (.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .count_tick(count_tick), .phase_up(phase_up), .phase_dn(phase_dn),
    .sync_clear(sync_clear), .cap_alt(cap_alt), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  tbcp_pins_model tbcp_pins_model_i (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .src(src), .pin_in(pin_in));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict();
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // one single transfer; waits only on ready, under a bound
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do begin
      @(posedge clk);
      n++;
    end while (!hreadyout && n < 40);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (!hreadyout && n < 40);
    r = hrdata;
    if (n >= 40) begin
      miscompares++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(r, e);
  endtask

  task automatic run_rows(input int n);
    for (int i = 0; i < n; i++) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].d);
      end
      rd_chk(rows[i].a, rows[i].e);
    end
  endtask

  // counts high cycles of one pin wire over a ten-tick period
  task automatic duty(input int c, input int p, input logic [31:0] e);
    logic [31:0] h;
    h = 32'h0;
    repeat (10) begin
      @(posedge clk);
      h = h + 32'(pin_in[c][p]);
    end
    chk(h, e);
  endtask

  task automatic step2(input logic dn);
    phase_up[2] <= !dn;
    phase_dn[2] <= dn;
    @(posedge clk);
    phase_up[2] <= 1'b0;
    phase_dn[2] <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    logic [31:0] b;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    run_rows(14);
    for (int c = 0; c < 5; c++) begin
      b = 32'(c) * 32'h20;
      wr(b + 32'h10, (c == 2) ? 32'h9 : 32'h3);
      wr(b + 32'h14, 32'h9);
      wr(b + 32'h18, 32'h5);
      wr(b + 32'h4, (c == 2) ? 32'h16 : 32'h12);
      wr(b + 32'h8, 32'h1);
      wr(b, 32'h15);
    end
    count_tick <= '1;
    @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    repeat (40) @(posedge clk);
    for (int c = 0; c < 5; c++) begin
      duty(c, 0, pe[c]);
      rd_chk(32'(c) * 32'h20 + 32'h10, ga[c]);
      wr(32'(c) * 32'h20, 32'h0);
    end
    wr(32'h8, 32'h0);
    wr(32'hc, 32'h0);
    wr(32'h10, 32'h2);
    wr(32'h18, 32'h9);
    wr(32'h4, 32'h222);
    wr(32'h0, 32'h25);
    repeat (30) @(posedge clk);
    duty(0, 0, 32'h7);
    duty(0, 2, 32'h0);
    chk(32'(pin_oe_n[0][1]), 32'h1);
    wr(32'h0, 32'h0);
    count_tick <= '0;
    wr(32'h10, 32'h42);
    wr(32'h4, 32'h8);
    wr(32'h8, 32'h1);
    wr(32'hc, 32'h123);
    wr(32'h0, 32'h1);
    src[0][0] <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(32'h10, 32'h123);
    rd_chk(32'h18, 32'h42);
    wr(32'h24, 32'h8);
    wr(32'h44, 32'hc);
    wr(32'ha8, 32'h5);
    wr(32'h2c, 32'h111);
    wr(32'h4c, 32'h222);
    wr(32'h20, 32'h1);
    wr(32'h40, 32'h1);
    src[2][0] <= 1'b1;
    repeat (4) @(posedge clk);
    wr(32'h2c, 32'h333);
    src[1][0] <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(32'h30, 32'h111);
    rd_chk(32'h50, 32'h9);
    cap_alt[2][0] <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(32'h50, 32'h222);
    wr(32'h4c, 32'hffff);
    wr(32'h2c, 32'h5);
    wr(32'h20, 32'h81);
    wr(32'h40, 32'h41);
    step2(1'b0);
    rd_chk(32'h2c, 32'h6);
    rd_chk(32'h4c, 32'h0);
    step2(1'b1);
    rd_chk(32'h2c, 32'h5);
    wr(32'h20, 32'hc1);
    step2(1'b0);
    rd_chk(32'h2c, 32'h5);
    for (int c = 3; c < 5; c++) begin
      b = 32'(c) * 32'h20;
      wr(b, 32'h0);
      wr(b + 32'h10, 32'h3);
      wr(b + 32'h18, 32'h7);
      wr(b + 32'h8, (c == 3) ? 32'h9 : 32'h1);
      wr(b, 32'h11);
      wr(b + 32'hc, 32'h0);
      rd_chk(b + 32'h10, (c == 3) ? 32'h7 : 32'h3);
    end
    wr(32'h80, 32'h0);
    wr(32'h88, 32'h0);
    wr(32'h90, 32'h1);
    wr(32'h84, 32'h3);
    wr(32'h80, 32'h27);
    count_tick[4] <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'(pin_out[4][0]), 32'h1);
    sync_clear[4] <= 1'b1;
    @(posedge clk);
    sync_clear[4] <= 1'b0;
    count_tick[4] <= 1'b0;
    @(posedge clk);
    chk(32'(pin_out[4][0]), 32'h0);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(pin_oe_n), 32'hfffff);
    rst_n <= 1'b1;
    @(posedge clk);
    run_rows(9);
    give_verdict();
  end
endmodule

bind tbcp_top tbcp_assertions tbcp_assertions_i (.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .count_tick(count_tick), .phase_up(phase_up), .phase_dn(phase_dn),
  .sync_clear(sync_clear), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
